// >>> hdl/digital_output_channel.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module digital_output_channel
  import dout_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYC,
  parameter int unsigned SEC_CYCLES = SEC_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire total_inc_t [NSTR-1:0] total_inc,
  input wire logic [NSTR-1:0][3:0] stream_limit_ev,
  input wire logic [NSTR-1:0] stream_fault,
  input wire logic [NAI-1:0][5:0] ain_limit_ev,
  input wire logic [NDI-1:0] din_alarm,
  input wire logic common_alarm,
  input wire logic [NSTR-1:0] batch_run,
  input wire calendar_t now,
  output logic contact_drive,
  output logic irq
);
  ctrl_t ctrl;
  logic [15:0] kfac, p_len, p_gap, dly, tb_per, tb_wid;
  calendar_t start;
  logic [7:0] src;
  logic [IRQ_W-1:0] istat, imask;
  logic wr_pend;
  logic [7:0] wa;
  logic [31:0] status_word;

  typedef enum logic [2:0] {
    P_IDLE = 3'b001, P_HIGH = 3'b010, P_GAP = 3'b100
  } pstate_t;
  pstate_t p_state;
  logic [31:0] p_cyc;
  logic [15:0] p_steps, pend, acc;
  logic pulse_on, ovf_ev;

  logic [3:0] sidx;
  logic sok, cond, out_state;
  logic [31:0] d_cyc;
  logic [15:0] d_sec;
  logic [31:0] s_cyc;
  logic [15:0] tb_sec;
  logic tb_started, tb_on, raw, on_ev;

  function automatic logic ev_hit(input logic [5:0] ev, input logic [2:0] sel);
    ev_hit = (sel < 3'h6) ? ev[sel] : 1'b0;
  endfunction

  // Stream indices are one-based; zero or out of range selects nothing.
  assign sidx = ctrl.stream - 4'h1;
  assign sok = (ctrl.stream != 4'h0) && (ctrl.stream <= 4'(NSTR));

  assign status_word = {16'h0, pend[7:0], 5'h0, tb_started, cond, out_state};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wa <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wa <= haddr[7:0];
        if (!hwrite) begin
          case (haddr[7:0])
            OFS_CTRL: hrdata <= {17'h0, ctrl[14:0]};
            OFS_KFAC: hrdata <= {16'h0, kfac};
            OFS_PULSE: hrdata <= {p_gap, p_len};
            OFS_DELAY: hrdata <= {16'h0, dly};
            OFS_TBASE: hrdata <= {tb_wid, tb_per};
            OFS_START: hrdata <= {5'h0, start};
            OFS_SRC: hrdata <= {24'h0, src};
            OFS_STAT: hrdata <= status_word;
            OFS_ISTAT: hrdata <= {29'h0, istat};
            OFS_IMASK: hrdata <= {29'h0, imask};
            default: hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Configuration registers, written in the data phase.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= RST_CTRL;
      kfac <= RST_KFAC[15:0];
      {p_gap, p_len} <= RST_PULSE;
      dly <= 16'h0000;
      {tb_wid, tb_per} <= RST_TBASE;
      start <= '0;
      src <= 8'h00;
      imask <= '0;
    end else if (ce && wr_pend) begin
      case (wa)
        OFS_CTRL: ctrl <= {17'h0, hwdata[14:0]};
        OFS_KFAC: kfac <= hwdata[15:0];
        OFS_PULSE: {p_gap, p_len} <= hwdata;
        OFS_DELAY: dly <= hwdata[15:0];
        OFS_TBASE: {tb_wid, tb_per} <= hwdata;
        OFS_START: start <= hwdata[26:0];
        OFS_SRC: src <= hwdata[7:0];
        OFS_IMASK: imask <= hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      istat <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      istat <= (istat & ~((wr_pend && wa == OFS_ISTAT) ? hwdata[IRQ_W-1:0] : '0))
               | {tb_on && !tb_started, ovf_ev, on_ev};
      irq <= |(istat & imask);
    end
  end

  logic inc, take, next_ovf;
  logic [16:0] sum;
  logic [15:0] next_pend, next_acc;

  // Pulse mode: owed pulses grow with the chosen total, by factor mode.
  always_comb begin
    inc = sok && ctrl.sig_type == T_PULSE && total_inc[sidx][3 - ctrl.quantity];
    take = p_state == P_IDLE && pend != 16'h0000 && ctrl.sig_type == T_PULSE;
    sum = {1'b0, pend} - {16'h0, take};
    next_acc = acc;
    if (inc && ctrl.per_unit) begin
      sum = sum + {1'b0, kfac};
    end else if (inc && acc + 16'h1 >= kfac) begin
      sum = sum + 17'h1;
      next_acc = 16'h0000;
    end else if (inc) begin
      next_acc = acc + 16'h1;
    end
    // Saturate rather than wrap so a burst never loses the whole backlog.
    next_ovf = sum[16];
    next_pend = sum[16] ? 16'hffff : sum[15:0];
    if (ctrl.sig_type != T_PULSE) begin
      next_pend = 16'h0000;
      next_acc = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 16'h0000;
      acc <= 16'h0000;
      ovf_ev <= 1'b0;
    end else if (ce) begin
      pend <= next_pend;
      acc <= next_acc;
      ovf_ev <= next_ovf;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      p_state <= P_IDLE;
      p_cyc <= 32'h0;
      p_steps <= 16'h0;
      pulse_on <= 1'b0;
    end else if (ce) begin
      case (p_state)
        P_IDLE: begin
          if (pend != 16'h0000 && ctrl.sig_type == T_PULSE) begin
            p_state <= P_HIGH;
            pulse_on <= 1'b1;
            p_cyc <= 32'h0;
            p_steps <= 16'h0;
          end
        end
        P_HIGH, P_GAP: begin
          p_cyc <= p_cyc + 32'h1;
          if (p_cyc == STEP_CYCLES - 1) begin
            p_cyc <= 32'h0;
            p_steps <= p_steps + 16'h1;
            // A zero length or gap still spends one step.
            if (p_state == P_HIGH && p_steps + 16'h1 >= p_len) begin
              p_state <= P_GAP;
              pulse_on <= 1'b0;
              p_steps <= 16'h0;
            end else if (p_state == P_GAP && p_steps + 16'h1 >= p_gap) begin
              p_state <= P_IDLE;
            end
          end
        end
        default: begin
          p_state <= P_IDLE;
          pulse_on <= 1'b0;
        end
      endcase
    end
  end

  // Alarm and batch condition selection.
  always_comb begin
    cond = 1'b0;
    case (ctrl.sig_type)
      T_RATE: cond = sok && ctrl.ev_sel != 3'h0
                     && ev_hit({2'b0, stream_limit_ev[sidx]}, ctrl.ev_sel - 3'h1);
      T_FAULT: cond = sok && stream_fault[sidx];
      T_AIN: cond = src < 8'(NAI) && ev_hit(ain_limit_ev[src[3:0]], ctrl.ev_sel);
      T_DIN: cond = src < 8'(NDI) && din_alarm[src[3:0]];
      T_COMMON: cond = common_alarm;
      T_BATCH: cond = sok && batch_run[sidx];
      default: cond = 1'b0;
    endcase
  end

  // The delay restarts whenever the condition falls back before expiry.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_state <= 1'b0;
      d_cyc <= 32'h0;
      d_sec <= 16'h0;
    end else if (ce) begin
      if (cond == out_state) begin
        d_cyc <= 32'h0;
        d_sec <= 16'h0;
      end else if (d_sec >= dly) begin
        out_state <= cond;
        d_cyc <= 32'h0;
        d_sec <= 16'h0;
      end else if (d_cyc == SEC_CYCLES - 1) begin
        d_cyc <= 32'h0;
        d_sec <= d_sec + 16'h1;
      end else begin
        d_cyc <= d_cyc + 32'h1;
      end
    end
  end

  // Time base: runs once the calendar reaches the start point.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb_started <= 1'b0;
      s_cyc <= 32'h0;
      tb_sec <= 16'h0;
    end else if (ce) begin
      tb_started <= tb_on;
      s_cyc <= (s_cyc == SEC_CYCLES - 1 || !tb_on) ? 32'h0 : s_cyc + 32'h1;
      if (!tb_on) begin
        tb_sec <= 16'h0;
      end else if (s_cyc == SEC_CYCLES - 1) begin
        tb_sec <= (tb_sec + 16'h1 >= tb_per) ? 16'h0 : tb_sec + 16'h1;
      end
    end
  end
  assign tb_on = ctrl.sig_type == T_TBASE && now >= start;

  always_comb begin
    case (ctrl.sig_type)
      T_PULSE: raw = pulse_on;
      T_TBASE: raw = tb_on && tb_sec < tb_wid;
      default: raw = out_state;
    endcase
  end
  assign on_ev = ctrl.active && raw && !(contact_drive ^ ctrl.nc);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      contact_drive <= 1'b0;
    end else if (ce) begin
      contact_drive <= ctrl.active ? (raw ^ ctrl.nc) : ctrl.nc;
    end
  end

  logic [31:0] hi_len, lo_len;
  logic gap_seen;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_len <= 32'h0;
      lo_len <= 32'h0;
      gap_seen <= 1'b0;
    end else if (ce) begin
      hi_len <= pulse_on ? hi_len + 32'h1 : 32'h0;
      lo_len <= pulse_on ? 32'h0 : lo_len + 32'h1;
      if (p_state == P_GAP) gap_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || !ce);

  a_inactive_hold: assert property (!ctrl.active |=> contact_drive == $past(ctrl.nc))
    else $error("inactive channel drove its contact");
  a_contact_sense: assert property (ctrl.active && $stable(ctrl) && $stable(out_state)
      && ctrl.sig_type == T_COMMON |=> contact_drive == ($past(out_state) ^ $past(ctrl.nc)))
    else $error("contact polarity wrong");
  a_pulse_width: assert property ($fell(pulse_on) && $stable(p_len) && p_len != 16'h0
      |-> hi_len == 32'(p_len) * STEP_CYCLES)
    else $error("pulse width wrong");
  a_pulse_gap: assert property ($rose(pulse_on) && gap_seen && $stable(p_gap)
      |-> $past(lo_len) >= 32'(p_gap) * STEP_CYCLES)
    else $error("gap between pulses too short");
  a_zero_delay: assert property (dly == 16'h0 && cond != out_state && $stable(dly)
      |=> out_state == $past(cond))
    else $error("zero delay output did not follow");
  a_delay_hold: assert property (dly != 16'h0 && cond != out_state && d_sec == 16'h0
      |=> out_state == $past(out_state))
    else $error("output changed before delay");
  a_stream_range: assert property (!sok && ctrl.sig_type inside {T_RATE, T_FAULT, T_BATCH}
      |-> !cond)
    else $error("invalid stream raised condition");
  a_fault_follow: assert property (sok && ctrl.sig_type == T_FAULT
      |-> cond == stream_fault[sidx])
    else $error("fault condition mismatch");
  a_common_follow: assert property (ctrl.sig_type == T_COMMON |-> cond == common_alarm)
    else $error("common alarm condition mismatch");
  a_pulse_take: assert property (p_state == P_IDLE && pend != 16'h0
      && ctrl.sig_type == T_PULSE |=> pulse_on)
    else $error("owed pulse not started");

  c_pulse: cover property ($rose(pulse_on) ##[1:1000] $rose(pulse_on));
  c_delayed: cover property (dly != 16'h0 && $rose(out_state));
  c_tbase: cover property ($rose(tb_on));
  c_irq: cover property ($rose(irq));
endmodule // digital_output_channel
`default_nettype wire

// >>> hdl/dout_pkg.sv
`default_nettype none
package dout_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int STEP_MS = 10;
  localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  localparam int SEC_S = 1;
  localparam int SEC_CYC = CLK_HZ * SEC_S;
  localparam int NSTR = 12;
  localparam int NAI = 16;
  localparam int NDI = 16;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KFAC = 8'h04;
  localparam logic [7:0] OFS_PULSE = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0c;
  localparam logic [7:0] OFS_TBASE = 8'h10;
  localparam logic [7:0] OFS_START = 8'h14;
  localparam logic [7:0] OFS_SRC = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_ISTAT = 8'h20;
  localparam logic [7:0] OFS_IMASK = 8'h24;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_KFAC = 32'h0000_0001;
  localparam logic [31:0] RST_PULSE = 32'h0001_0001;
  localparam logic [31:0] RST_TBASE = 32'h0001_0001;
  localparam int IRQ_W = 3;
  localparam int IRQ_ON = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_TB = 2;
  localparam int GAP_LSB = 16;
  localparam int TBW_LSB = 16;

  typedef enum logic [2:0] {
    T_PULSE = 3'h0, T_RATE = 3'h1, T_FAULT = 3'h2, T_AIN = 3'h3,
    T_DIN = 3'h4, T_COMMON = 3'h5, T_TBASE = 3'h6, T_BATCH = 3'h7
  } sig_type_t;

  typedef enum logic [1:0] {
    Q_BASE = 2'h0, Q_LINE = 2'h1, Q_MASS = 2'h2, Q_ENERGY = 2'h3
  } quantity_t;

  typedef struct packed {
    logic [16:0] rsvd;
    logic [2:0] ev_sel;
    logic per_unit;
    quantity_t quantity;
    logic [3:0] stream;
    sig_type_t sig_type;
    logic nc;
    logic active;
  } ctrl_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
  } calendar_t;

  typedef struct packed {
    logic base_volume_total;
    logic line_volume_total;
    logic mass_total;
    logic energy_total;
  } total_inc_t;
endpackage
`default_nettype wire

// >>> testbench/field_contact.sv
`timescale 1ns/10ps
`default_nettype none
// Field side only senses the contact; it never drives back, so it just counts closures and times the closed and open runs.
module field_contact (
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic contact_drive,
  output var int closes,
  output var int hi_min,
  output var int hi_max,
  output var int lo_min
);
  int run;
  logic last;
  always @(posedge ref_clk) begin
    if (clr) begin
      closes <= 0;
      hi_min <= 32'h7fffffff;
      hi_max <= 0;
      lo_min <= 32'h7fffffff;
      run <= 0;
    end else if (contact_drive !== last) begin
      if (last === 1'b1) begin
        if (run < hi_min) hi_min <= run;
        if (run > hi_max) hi_max <= run;
      end else if (closes > 0 && run < lo_min) begin
        lo_min <= run;
      end
      if (contact_drive === 1'b1) closes <= closes + 1;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last <= contact_drive;
  end
endmodule // field_contact
`default_nettype wire

// >>> testbench/digital_output_channel_tb.sv
`timescale 1ns/10ps
`default_nettype none
module digital_output_channel_tb;
  import dout_pkg::*;
  // Short step and second keep the whole run within a few thousand cycles.
  localparam int SC = 10;
  localparam int SE = 20;
  localparam logic [26:0] ST = {7'h18, 4'h5, 5'h0e, 5'h0e, 6'h00};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, contact_drive, irq;
  logic [31:0] hrdata, rd;
  total_inc_t [NSTR-1:0] total_inc = '0;
  logic [NSTR-1:0][3:0] stream_limit_ev = '0;
  logic [NSTR-1:0] stream_fault = '0;
  logic [NAI-1:0][5:0] ain_limit_ev = '0;
  logic [NDI-1:0] din_alarm = '0;
  logic common_alarm = 1'b0;
  logic [NSTR-1:0] batch_run = '0;
  calendar_t now = '0;
  logic clr = 1'b1;
  int closes, hi_min, hi_max, lo_min;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] seed = 32'ha7feedee;
  always #5 ref_clk = ~ref_clk;

  digital_output_channel #(.STEP_CYCLES(SC), .SEC_CYCLES(SE)) dut (
    .ref_clk, .rst_b, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .total_inc, .stream_limit_ev,
    .stream_fault, .ain_limit_ev, .din_alarm, .common_alarm, .batch_run, .now,
    .contact_drive, .irq);
  field_contact fc (.ref_clk, .clr, .contact_drive, .closes, .hi_min, .hi_max, .lo_min);

  function automatic int ri(input int n);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % n);
  endfunction

  function automatic int exp_pulses(input int pu, input int n, input int k);
    return (pu != 0) ? n * k : n / k;
  endfunction

  task automatic results();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cond(input int t, input int s, input int e, input logic v);
    @(posedge ref_clk);
    case (t)
      1: stream_limit_ev[s-1][e-1] <= v;
      2: stream_fault[s-1] <= v;
      3: ain_limit_ev[s][e] <= v;
      4: din_alarm[s] <= v;
      5: common_alarm <= v;
      default: batch_run[s-1] <= v;
    endcase
  endtask

  task automatic unit(input int s, input int q, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      total_inc[s-1][3-q] <= 1'b1;
      @(posedge ref_clk);
      total_inc[s-1][3-q] <= 1'b0;
    end
  endtask

  task automatic clear_meter();
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    results();
  end

  initial begin
    int t, s, o, e, d, k, n, q, len, gap, p;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(0, OFS_CTRL, 0);
    check(rd, RST_CTRL);
    check(hresp, 0);
    bus(0, OFS_KFAC, 0);
    check(rd, RST_KFAC);
    bus(0, OFS_PULSE, 0);
    check(rd, RST_PULSE);
    bus(0, OFS_TBASE, 0);
    check(rd, RST_TBASE);
    bus(0, 8'h40, 0);
    check(rd, 0);
    check(contact_drive, 0);
    for (t = 1; t < 8; t++) begin
      if (t == 6) continue;
      s = (t == 3 || t == 4) ? ri(16) : 1 + ri(12);
      o = (t == 3 || t == 4) ? (s + 1) % 16 : s % 12 + 1;
      e = (t == 1) ? 1 + ri(4) : ri(6);
      d = t % 2;
      bus(1, OFS_SRC, s);
      bus(1, OFS_DELAY, d);
      bus(1, OFS_CTRL, 32'h1 | t << 2 | s << 5 | e << 12);
      if (t != 5) begin
        cond(t, o, e, 1);
        wt(4 + d * SE);
        check(contact_drive, 0);
        cond(t, o, e, 0);
      end
      cond(t, s, e, 1);
      wt(d ? SE - 4 : 1);
      check(contact_drive, 0);
      wt(d ? 10 : 3);
      check(contact_drive, 1);
      cond(t, s, e, 0);
      wt(d ? SE - 4 : 1);
      check(contact_drive, 1);
      wt(d ? 10 : 3);
      check(contact_drive, 0);
    end
    bus(1, OFS_CTRL, 32'h1 | 1 << 2 | 1 << 5);
    @(posedge ref_clk);
    stream_limit_ev[0] <= 4'hf;
    wt(5);
    check(contact_drive, 0);
    @(posedge ref_clk);
    stream_limit_ev[0] <= 4'h0;
    // Polarity and interrupt checks below expect the alarm to follow without delay.
    bus(1, OFS_DELAY, 0);
    bus(1, OFS_CTRL, 32'h3 | 5 << 2);
    wt(3);
    check(contact_drive, 1);
    cond(5, 0, 0, 1);
    wt(4);
    check(contact_drive, 0);
    bus(1, OFS_CTRL, 32'h2 | 5 << 2);
    wt(3);
    check(contact_drive, 1);
    bus(1, OFS_CTRL, 5 << 2);
    wt(3);
    check(contact_drive, 0);
    cond(5, 0, 0, 0);
    bus(1, OFS_ISTAT, 32'h7);
    bus(1, OFS_CTRL, 32'h1 | 5 << 2);
    cond(5, 0, 0, 1);
    wt(4);
    bus(0, OFS_ISTAT, 0);
    check(rd & 32'h1, 1);
    check(irq, 0);
    bus(1, OFS_IMASK, 1);
    wt(2);
    check(irq, 1);
    bus(1, OFS_ISTAT, 1);
    wt(2);
    check(irq, 0);
    cond(5, 0, 0, 0);
    bus(1, OFS_IMASK, 0);
    for (q = 0; q < 4; q++) begin
      s = 1 + ri(12);
      k = 1 + ri(3);
      len = 1 + ri(4);
      gap = 1 + ri(4);
      n = (q % 2) ? 2 : 6;
      bus(1, OFS_KFAC, k);
      bus(1, OFS_PULSE, gap << 16 | len);
      bus(1, OFS_CTRL, 32'h1 | s << 5 | q << 9 | (q % 2) << 11);
      clear_meter();
      unit(s, (q + 1) % 4, n);
      unit(s, q, n);
      p = exp_pulses(q % 2, n, k);
      wt(p * (len + gap + 2) * SC + 20);
      check(closes, p);
      check(hi_min, len * SC);
      check(hi_max, len * SC);
      check(lo_min >= gap * SC, 1);
    end
    // A write made while the clock enable is low must not land.
    @(posedge ref_clk);
    ce <= 1'b0;
    bus(1, OFS_DELAY, 32'h5);
    @(posedge ref_clk);
    ce <= 1'b1;
    bus(0, OFS_DELAY, 0);
    check(rd, 0);
    bus(1, OFS_START, ST);
    bus(1, OFS_TBASE, 32'h0001_0003);
    @(posedge ref_clk);
    now <= ST - 27'h1;
    bus(1, OFS_CTRL, 32'h1 | 6 << 2);
    clear_meter();
    wt(3 * SE);
    check(closes, 0);
    @(posedge ref_clk);
    now <= ST;
    wt(10 * SE);
    check(closes >= 3, 1);
    check(hi_max, SE);
    check(lo_min, 2 * SE);
    results();
  end
endmodule // digital_output_channel_tb
`default_nettype wire
